/* File: hdl/ancs_pkg.sv */
// package for the auto-negotiation control and status block
// assumes a 25 MHz device clock and a management register port of 5-bit index, 16-bit data
package ancs_pkg;
  localparam logic [4:0]  REG_BASIC_CONTROL   = 5'h00;
  localparam logic [4:0]  REG_BASIC_STATUS    = 5'h01;
  localparam logic [4:0]  REG_ADVERT_ABILITY  = 5'h04;
  localparam logic [4:0]  REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0]  REG_NEG_EXPANSION   = 5'h06;
  localparam logic [4:0]  REG_NEXT_PAGE_TX    = 5'h07;
  // basic control fields
  localparam int CTL_SPEED   = 13;
  localparam int CTL_AN_EN   = 12;
  localparam int CTL_RESTART = 9;
  localparam int CTL_DUPLEX  = 8;
  // basic status fields
  localparam logic [15:0] STS_FIXED      = 16'h7809;
  localparam int          STS_AN_DONE    = 5;
  localparam int          STS_RFAULT     = 4;
  localparam int          STS_LINK       = 2;
  localparam int          STS_PREAMBLE   = 6;
  // ability fields
  localparam int ABL_10HD  = 5;
  localparam int ABL_100HD = 7;
  localparam int ABL_RFAULT = 13;
  localparam int ABL_NP    = 15;
  // expansion fields
  localparam int EXP_PD_FAULT = 4;
  localparam int EXP_LP_NP    = 3;
  localparam int EXP_NP_ABLE  = 2;
  localparam int EXP_PAGE_RX  = 1;
  localparam int EXP_LP_AN    = 0;
  // reset values and parallel detect partner words
  localparam logic [15:0] CONTROL_RESET   = 16'h1000;
  localparam logic [15:0] ADVERT_RESET    = 16'h01E1;
  localparam logic [15:0] NEXT_PAGE_RESET = 16'h2001;
  localparam logic [15:0] PD_100_WORD     = 16'h0081;
  localparam logic [15:0] PD_10_WORD      = 16'h0021;
  // timing
  localparam int CLOCK_HZ         = 25000000;
  localparam int BREAK_LINK_MS    = 1500;
  localparam int MS_CYCLES        = CLOCK_HZ / 1000;
  localparam int LINK_CHECK_MS    = 50;
  localparam int AN_TIMEOUT_MS    = 3000;

  typedef enum logic [2:0] {
    ANCS_DISABLED, ANCS_BREAK, ANCS_ABILITY, ANCS_ACK, ANCS_NEXT_WAIT, ANCS_LINK_CHECK,
    ANCS_GOOD
  } ancs_state_t;

  // code word exchange with the line side
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
    logic        ack;
  } ancs_page_t;

  typedef struct packed {
    logic        speed_100;
    logic        full_duplex;
    logic        link_up;
    logic        tx_quiet;
    logic        flp_enable;
  } ancs_mode_t;
endpackage : ancs_pkg

/* File: hdl/ancs_tick.sv */
// millisecond tick divider for the negotiation timers
// assumes one clock; the prescale may be shrunk for simulation
`timescale 1ns/100ps
module ancs_tick #(
  parameter int PRESCALE = ancs_pkg::MS_CYCLES
) (
  input  wire logic CLOCK,
  input  wire logic RSTN,
  output logic      TICK
);
  typedef struct packed {
    logic [24:0] count;
    logic        tick;
  } ancs_tick_st_t;

  ancs_tick_st_t st;
  ancs_tick_st_t next_st;

  // count down and pulse once per period
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count == 25'h0000000)
    begin
      next_st.count = 25'(PRESCALE - 1);
      next_st.tick  = 1'b1;
    end
    else
      next_st.count = st.count - 25'h0000001;
  end

  // state register
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      st <= '0;
    else
      st <= next_st;
  end

  assign TICK = st.tick;
endmodule : ancs_tick

/* File: hdl/ancs_top.sv */
// auto-negotiation control and status for a 10/100 physical layer
// assumes line-side link, burst and page valid signals are asynchronous and pass two flip-flops here; the page word is taken unsynchronised
//
// Notes on behaviour
// - negotiation off: control speed and duplex bits pick the operating mode
// - negotiation on: speed and duplex bits are ignored
// - status shows fixed ability bits, all technologies except T4
// - status shows complete, remote fault, link, preamble suppression
// - advert register holds abilities; all set by default; cleared bits withdraw ability
// - partner register takes base page then each next page
// - parallel detect loads 0081h for 100 or 0021h for 10
// - without next pages, base page kept from page received onward
// - hidden base page copy kept for resolution
// - expansion shows pd fault, partner np, local np, page rx, partner an
// - next page transmit register holds next code word to send
// - parallel detect accepts link only from advertised receiver
// - no common ability means negotiation stays incomplete, no mode configured
// - parallel detect sets matching bit and selector 00001
// - parallel detect completion reads partner an able zero unless a page was received since the last restart
// - parallel detect fault sets when, without bursts, a receiver has link but not exactly one good link
// - restart bit restarts negotiation at any time except in forced mode before enable is cleared then set
// - configured link lost resumes negotiation
// - renegotiation silences line for break-link period then sends bursts
// - forced mode at reset needs enable cleared then set to start
// - negotiation finishes in about two to three seconds
// - reset loads advert value 1E1h
`timescale 1ns/100ps
module ancs_top #(
  parameter int PRESCALE      = ancs_pkg::MS_CYCLES,
  parameter int BREAK_LINK_MS = ancs_pkg::BREAK_LINK_MS,
  parameter int LINK_CHECK_MS = ancs_pkg::LINK_CHECK_MS,
  parameter int TIMEOUT_MS    = ancs_pkg::AN_TIMEOUT_MS
) (
  input  wire logic               CLOCK,
  input  wire logic               RSTN,
  input  wire logic               FORCED_AT_RESET,
  input  wire logic               REG_WRITE,
  input  wire logic               REG_READ,
  input  wire logic [4:0]         REG_INDEX,
  input  wire logic [15:0]        REG_WDATA,
  output logic      [15:0]        REG_RDATA,
  input  wire logic               LINK_10_OK,
  input  wire logic               LINK_100_OK,
  input  wire logic               FLP_DETECTED,
  input  wire ancs_pkg::ancs_page_t RX_PAGE,
  output ancs_pkg::ancs_page_t    TX_PAGE,
  output ancs_pkg::ancs_mode_t    MODE
);
  typedef struct packed {
    ancs_pkg::ancs_state_t fsm;
    logic [15:0] control;
    logic [15:0] advert;
    logic [15:0] partner;
    logic [15:0] base_copy;
    logic [15:0] next_tx;
    logic        an_done;
    logic        pd_done;
    logic        pd_fault;
    logic        page_rx;
    logic        lp_an;
    logic        armed;
    logic        en_seen_clear;
    logic [11:0] ms;
    logic [15:0] rdata;
    logic        tx_valid;
    logic        tx_ack;
    logic [15:0] tx_word;
    logic [2:0]  sync_l10;
    logic [2:0]  sync_l100;
    logic [2:0]  sync_flp;
    logic [2:0]  sync_rxv;
    logic        speed_100;
    logic        full_duplex;
    logic        link_up;
    logic        started;
  } ancs_st_t;

  ancs_st_t st;
  ancs_st_t next_st;
  logic     tick;

  // highest common ability, returns {configured, speed_100, full_duplex}
  function automatic logic [2:0] resolve(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] c;
    c = a & b;
    if (c[8])
      resolve = 3'h7;
    else if (c[7])
      resolve = 3'h6;
    else if (c[6])
      resolve = 3'h5;
    else if (c[5])
      resolve = 3'h4;
    else
      resolve = 3'h0;
  endfunction : resolve

  ancs_tick #(
    .PRESCALE (PRESCALE)
  ) u_tick (
    .CLOCK (CLOCK),
    .RSTN  (RSTN),
    .TICK  (tick)
  );

  // next state: register port, synchronisers and negotiation sequence
  always_comb
  begin
    logic l10;
    logic l100;
    logic good10;
    logic good100;
    logic rx_new;
    logic restart;
    logic [2:0] res;
    l10     = 1'b0;
    l100    = 1'b0;
    good10  = 1'b0;
    good100 = 1'b0;
    rx_new  = 1'b0;
    restart = 1'b0;
    res     = 3'h0;
    next_st = st;
    next_st.sync_l10  = {st.sync_l10[1:0], LINK_10_OK};
    next_st.sync_l100 = {st.sync_l100[1:0], LINK_100_OK};
    next_st.sync_flp  = {st.sync_flp[1:0], FLP_DETECTED};
    next_st.sync_rxv  = {st.sync_rxv[1:0], RX_PAGE.valid};
    l10    = st.sync_l10[1];
    l100   = st.sync_l100[1];
    rx_new = st.sync_rxv[1] & ~st.sync_rxv[2];
    good10  = l10 & st.advert[ancs_pkg::ABL_10HD];
    good100 = l100 & st.advert[ancs_pkg::ABL_100HD];
    if (tick && st.ms != 12'hFFF)
      next_st.ms = st.ms + 12'h001;
    // register reads: status fields are live
    next_st.rdata = 16'h0000;
    if (REG_READ)
    begin
      unique case (REG_INDEX)
        ancs_pkg::REG_BASIC_CONTROL:   next_st.rdata = st.control;
        ancs_pkg::REG_BASIC_STATUS:
        begin
          next_st.rdata = ancs_pkg::STS_FIXED;
          next_st.rdata[ancs_pkg::STS_AN_DONE]  = st.an_done;
          // remote fault comes from the base page, which next pages may have overwritten
          next_st.rdata[ancs_pkg::STS_RFAULT]   = st.base_copy[ancs_pkg::ABL_RFAULT] & st.lp_an;
          next_st.rdata[ancs_pkg::STS_LINK]     = st.link_up;
          next_st.rdata[ancs_pkg::STS_PREAMBLE] = 1'b1;
        end
        ancs_pkg::REG_ADVERT_ABILITY:  next_st.rdata = st.advert;
        ancs_pkg::REG_PARTNER_ABILITY: next_st.rdata = st.partner;
        ancs_pkg::REG_NEG_EXPANSION:
        begin
          next_st.rdata[ancs_pkg::EXP_PD_FAULT] = st.pd_fault;
          next_st.rdata[ancs_pkg::EXP_LP_NP]    = st.base_copy[ancs_pkg::ABL_NP] & st.lp_an;
          next_st.rdata[ancs_pkg::EXP_NP_ABLE]  = 1'b1;
          next_st.rdata[ancs_pkg::EXP_PAGE_RX]  = st.page_rx;
          next_st.rdata[ancs_pkg::EXP_LP_AN]    = st.lp_an;
        end
        ancs_pkg::REG_NEXT_PAGE_TX:    next_st.rdata = st.next_tx;
        default:                       next_st.rdata = 16'h0000;
      endcase
      // reading the expansion register clears page received; a new page wins below
      if (REG_INDEX == ancs_pkg::REG_NEG_EXPANSION)
        next_st.page_rx = 1'b0;
    end
    // register writes
    if (REG_WRITE)
    begin
      unique case (REG_INDEX)
        ancs_pkg::REG_BASIC_CONTROL:
        begin
          next_st.control = REG_WDATA;
          next_st.control[ancs_pkg::CTL_RESTART] = 1'b0;
          restart = REG_WDATA[ancs_pkg::CTL_RESTART] & REG_WDATA[ancs_pkg::CTL_AN_EN];
          if (!REG_WDATA[ancs_pkg::CTL_AN_EN])
            next_st.en_seen_clear = 1'b1;
          if (REG_WDATA[ancs_pkg::CTL_AN_EN] && st.en_seen_clear && !st.armed)
          begin
            next_st.armed = 1'b1;
            restart = 1'b1;
          end
        end
        ancs_pkg::REG_ADVERT_ABILITY: next_st.advert = REG_WDATA;
        ancs_pkg::REG_NEXT_PAGE_TX:   next_st.next_tx = REG_WDATA;
        default:                      next_st.next_tx = next_st.next_tx;
      endcase
    end
    // page capture: every page received in ability or next-page wait lands in partner register
    if (rx_new && (st.fsm == ancs_pkg::ANCS_ABILITY || st.fsm == ancs_pkg::ANCS_NEXT_WAIT))
    begin
      next_st.partner = RX_PAGE.word;
      next_st.page_rx = 1'b1;
      next_st.lp_an   = 1'b1;
      if (st.fsm == ancs_pkg::ANCS_ABILITY)
        next_st.base_copy = RX_PAGE.word;
    end
    next_st.tx_ack = 1'b0;
    // negotiation sequence
    if (!st.control[ancs_pkg::CTL_AN_EN] || !st.armed)
    begin
      next_st.fsm         = ancs_pkg::ANCS_DISABLED;
      next_st.an_done     = 1'b0;
      next_st.speed_100   = st.control[ancs_pkg::CTL_SPEED];
      next_st.full_duplex = st.control[ancs_pkg::CTL_DUPLEX];
      next_st.link_up     = st.control[ancs_pkg::CTL_SPEED] ? l100 : l10;
      next_st.tx_valid    = 1'b0;
    end
    else if (restart || st.fsm == ancs_pkg::ANCS_DISABLED)
    begin
      next_st.fsm      = ancs_pkg::ANCS_BREAK;
      next_st.ms       = 12'h000;
      next_st.an_done  = 1'b0;
      next_st.pd_done  = 1'b0;
      next_st.lp_an    = 1'b0;
      next_st.link_up  = 1'b0;
      next_st.tx_valid = 1'b0;
      next_st.started  = 1'b1;
    end
    else
    begin
      unique case (st.fsm)
        ancs_pkg::ANCS_BREAK:
          if (st.ms >= 12'(BREAK_LINK_MS))
          begin
            next_st.fsm      = ancs_pkg::ANCS_ABILITY;
            next_st.ms       = 12'h000;
            next_st.tx_word  = st.advert;
            next_st.tx_valid = 1'b1;
          end
        ancs_pkg::ANCS_ABILITY:
        begin
          if (rx_new)
            next_st.fsm = ancs_pkg::ANCS_ACK;
          else if (!st.sync_flp[1] && (good10 ^ good100))
          begin
            // parallel detection of a non-negotiating partner
            next_st.partner  = good100 ? ancs_pkg::PD_100_WORD : ancs_pkg::PD_10_WORD;
            next_st.pd_done  = 1'b1;
            next_st.pd_fault = 1'b0;
            next_st.fsm      = ancs_pkg::ANCS_LINK_CHECK;
            next_st.ms       = 12'h000;
          end
          else if (!st.sync_flp[1] && (l10 || l100) && !(good10 ^ good100))
            next_st.pd_fault = 1'b1;
          else if (st.ms >= 12'(TIMEOUT_MS))
          begin
            // a retry needs a full silent break, so the timer starts again
            next_st.fsm      = ancs_pkg::ANCS_BREAK;
            next_st.ms       = 12'h000;
            next_st.tx_valid = 1'b0;
          end
        end
        ancs_pkg::ANCS_ACK:
        begin
          next_st.tx_ack = 1'b1;
          if (st.partner[ancs_pkg::ABL_NP] || st.next_tx[ancs_pkg::ABL_NP])
          begin
            next_st.fsm      = ancs_pkg::ANCS_NEXT_WAIT;
            next_st.tx_word  = st.next_tx;
            next_st.ms       = 12'h000;
          end
          else
          begin
            next_st.fsm = ancs_pkg::ANCS_LINK_CHECK;
            next_st.ms  = 12'h000;
          end
        end
        ancs_pkg::ANCS_NEXT_WAIT:
        begin
          next_st.tx_word = st.next_tx; // software loads the page while we wait
          if (rx_new)
            next_st.fsm = ancs_pkg::ANCS_ACK;
          else if (st.ms >= 12'(TIMEOUT_MS))
          begin
            next_st.fsm      = ancs_pkg::ANCS_BREAK;
            next_st.ms       = 12'h000;
            next_st.tx_valid = 1'b0;
          end
        end
        ancs_pkg::ANCS_LINK_CHECK:
        begin
          next_st.tx_valid = 1'b0;
          res = st.pd_done ? resolve(st.advert, st.partner) : resolve(st.advert, st.base_copy);
          if (res[2] && (res[1] ? l100 : l10))
          begin
            next_st.fsm         = ancs_pkg::ANCS_GOOD;
            next_st.an_done     = 1'b1;
            next_st.speed_100   = res[1];
            next_st.full_duplex = res[0];
            next_st.link_up     = 1'b1;
          end
          else if (st.ms >= 12'(LINK_CHECK_MS) && !res[2])
            next_st.fsm = ancs_pkg::ANCS_LINK_CHECK;
          else if (st.ms >= 12'(TIMEOUT_MS))
          begin
            next_st.fsm = ancs_pkg::ANCS_BREAK;
            next_st.ms  = 12'h000;
          end
        end
        ancs_pkg::ANCS_GOOD:
          if (!(st.speed_100 ? l100 : l10))
          begin
            next_st.fsm     = ancs_pkg::ANCS_BREAK;
            next_st.ms      = 12'h000;
            next_st.an_done = 1'b0;
            next_st.link_up = 1'b0;
          end
        default:
          next_st.fsm = ancs_pkg::ANCS_DISABLED;
      endcase
    end
  end

  // state register; forced strap caught after release of reset
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st         <= '0;
      st.control <= ancs_pkg::CONTROL_RESET;
      st.advert  <= ancs_pkg::ADVERT_RESET;
      st.next_tx <= ancs_pkg::NEXT_PAGE_RESET;
      st.armed   <= 1'b1;
    end
    else if (!st.started && st.fsm == ancs_pkg::ANCS_DISABLED && FORCED_AT_RESET)
    begin
      st         <= next_st;
      st.armed   <= 1'b0;
      st.fsm     <= ancs_pkg::ANCS_DISABLED; // no stray break cycle in forced mode
      st.control <= st.control & ~(16'h0001 << ancs_pkg::CTL_AN_EN);
      st.started <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign REG_RDATA         = st.rdata;
  assign TX_PAGE.valid     = st.tx_valid;
  assign TX_PAGE.word      = st.tx_word;
  assign TX_PAGE.ack       = st.tx_ack;
  assign MODE.speed_100    = st.speed_100;
  assign MODE.full_duplex  = st.full_duplex;
  assign MODE.link_up      = st.link_up;
  assign MODE.tx_quiet     = (st.fsm == ancs_pkg::ANCS_BREAK);
  assign MODE.flp_enable   = st.tx_valid;
endmodule : ancs_top

/* File: sim/ancs_partner.sv */
// remote link partner model: receiver link levels, burst detect, page sender
// assumes the bench drives it through its tasks; a released page line is inverted
`timescale 1ns/100ps
module ancs_partner (
  input  wire logic                 CLOCK,
  input  wire ancs_pkg::ancs_page_t TX_PAGE,
  output logic                      LINK_10_OK,
  output logic                      LINK_100_OK,
  output logic                      FLP_DETECTED,
  output ancs_pkg::ancs_page_t      RX_PAGE
);
  // quiet line at time zero
  initial
  begin
    {LINK_10_OK, LINK_100_OK, FLP_DETECTED} = 3'h0;
    RX_PAGE = '0;
  end

  // what the local receivers report of the cable
  task automatic set_line(input logic l10, input logic l100, input logic flp);
    @(posedge CLOCK);
    LINK_10_OK   <= l10;
    LINK_100_OK  <= l100;
    FLP_DETECTED <= flp;
  endtask : set_line

  // hold a code word until the device accepts it, then release the line
  task automatic send_page(input logic [15:0] word);
    @(posedge CLOCK);
    RX_PAGE <= '{valid: 1'b1, word: word, ack: 1'b1};
    for (int n = 0; n < 64 && TX_PAGE.ack !== 1'b1; n++)
      @(posedge CLOCK);
    repeat (4) @(posedge CLOCK);
    RX_PAGE <= '{valid: 1'b0, word: ~word, ack: 1'b0};
  endtask : send_page
endmodule : ancs_partner

/* File: sim/ancs_top_assertions.sv */
// port checks for the auto-negotiation control and status block
// assumes binding into ancs_top with its timer parameters handed on
`timescale 1ns/100ps
module ancs_top_assertions #(
  parameter int PRESCALE      = 10,
  parameter int BREAK_LINK_MS = 4
) (
  input wire logic                 CLOCK,
  input wire logic                 RSTN,
  input wire logic                 REG_READ,
  input wire logic [4:0]           REG_INDEX,
  input wire logic [15:0]          REG_RDATA,
  input wire logic                 LINK_10_OK,
  input wire logic                 LINK_100_OK,
  input wire ancs_pkg::ancs_page_t TX_PAGE,
  input wire ancs_pkg::ancs_mode_t MODE
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RSTN);

  logic [15:0] quiet_len;

  // length of the current silent spell on the line
  always_ff @(posedge CLOCK or negedge RSTN)
  begin
    if (!RSTN)
      quiet_len <= 16'h0000;
    else if (MODE.tx_quiet)
      quiet_len <= quiet_len + 16'h0001;
    else
      quiet_len <= 16'h0000;
  end

  chk_status_fixed: assert property (
    $past(REG_READ) && $past(REG_INDEX) == 5'h01 |-> (REG_RDATA & 16'hF849) == 16'h7849)
    else $error("status ability bits wrong");
  chk_np_able: assert property (
    $past(REG_READ) && $past(REG_INDEX) == 5'h06 |-> REG_RDATA[2])
    else $error("local next page ability not set");
  chk_quiet_silent: assert property (
    MODE.tx_quiet |-> !TX_PAGE.valid && !MODE.flp_enable)
    else $error("line not silent during break");
  chk_quiet_no_link: assert property (
    MODE.tx_quiet |-> !MODE.link_up)
    else $error("link up during break");
  chk_break_length: assert property (
    $fell(MODE.tx_quiet) && $past(RSTN) |-> quiet_len >= (BREAK_LINK_MS - 1) * PRESCALE)
    else $error("break period too short");
  chk_ack_pulse: assert property (
    TX_PAGE.ack |=> !TX_PAGE.ack)
    else $error("page accept longer than one cycle");
  chk_link_cause: assert property (
    $rose(MODE.link_up) |-> $past(LINK_10_OK || LINK_100_OK, 3))
    else $error("link up without a receiver link");
  chk_link_loss: assert property (
    !(LINK_10_OK || LINK_100_OK) [*4] |-> ##[0:400] !MODE.link_up)
    else $error("link kept after receivers lost it");
endmodule : ancs_top_assertions

/* File: sim/ancs_top_test.sv */
// self-checking bench for the auto-negotiation control and status block
// assumes shortened timers and the partner model on the line side
`timescale 1ns/100ps
module ancs_top_test;
  logic                 CLOCK;
  logic                 RSTN;
  logic                 FORCED_AT_RESET;
  logic                 REG_WRITE;
  logic                 REG_READ;
  logic [4:0]           REG_INDEX;
  logic [15:0]          REG_WDATA;
  logic [15:0]          REG_RDATA;
  logic [15:0]          rv;
  logic                 LINK_10_OK;
  logic                 LINK_100_OK;
  logic                 FLP_DETECTED;
  ancs_pkg::ancs_page_t RX_PAGE;
  ancs_pkg::ancs_page_t TX_PAGE;
  ancs_pkg::ancs_mode_t MODE;
  int                   miscompares;
  int                   num_checks;
  int                   i;
  int                   k;
  logic [4:0]  rs_idx [7] = '{5'h00, 5'h01, 5'h04, 5'h05, 5'h06, 5'h07, 5'h02};
  logic [15:0] rs_msk [7] = '{16'hFFFF, 16'hF869, 16'hFFFF, 16'hFFFF, 16'h0004, 16'hFFFF,
                              16'hFFFF};
  logic [15:0] rs_exp [7] = '{16'h1000, 16'h7849, 16'h01E1, 16'h0000, 16'h0004, 16'h2001,
                              16'h0000};
  logic [15:0] pd_adv [4] = '{16'h01E1, 16'h01E1, 16'h0181, 16'h01E1};
  logic [1:0]  pd_lnk [4] = '{2'b01, 2'b10, 2'b10, 2'b11};
  logic [15:0] pd_lp  [2] = '{16'h0081, 16'h0021};

  ancs_top #(.PRESCALE(10), .BREAK_LINK_MS(4), .LINK_CHECK_MS(3), .TIMEOUT_MS(20)) dut_u (
    .CLOCK(CLOCK), .RSTN(RSTN), .FORCED_AT_RESET(FORCED_AT_RESET), .REG_WRITE(REG_WRITE),
    .REG_READ(REG_READ), .REG_INDEX(REG_INDEX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .LINK_10_OK(LINK_10_OK), .LINK_100_OK(LINK_100_OK), .FLP_DETECTED(FLP_DETECTED),
    .RX_PAGE(RX_PAGE), .TX_PAGE(TX_PAGE), .MODE(MODE));
  ancs_partner partner_u (
    .CLOCK(CLOCK), .TX_PAGE(TX_PAGE), .LINK_10_OK(LINK_10_OK), .LINK_100_OK(LINK_100_OK),
    .FLP_DETECTED(FLP_DETECTED), .RX_PAGE(RX_PAGE));

  // 25 MHz clock
  initial
  begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic do_reset(input logic forced);
    RSTN            <= 1'b0;
    FORCED_AT_RESET <= forced;
    repeat (20) @(posedge CLOCK);
    RSTN <= 1'b1;
    repeat (2) @(posedge CLOCK);
  endtask : do_reset

  // one-cycle management write, then one-cycle read with the answer a cycle later
  task automatic wr(input logic [4:0] idx, input logic [15:0] data);
    @(posedge CLOCK);
    REG_WRITE <= 1'b1;
    REG_INDEX <= idx;
    REG_WDATA <= data;
    @(posedge CLOCK);
    REG_WRITE <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] idx);
    @(posedge CLOCK);
    REG_READ  <= 1'b1;
    REG_INDEX <= idx;
    @(posedge CLOCK);
    REG_READ <= 1'b0;
    #1;
    rv = REG_RDATA;
  endtask : rd

  task automatic rdc(input logic [4:0] idx, input logic [15:0] msk, input logic [15:0] exp,
                     input string what);
    rd(idx);
    check(what, exp, rv & msk);
  endtask : rdc

  // software poll of the page received flag
  task automatic poll_page;
    rv = 16'h0000;
    for (int n = 0; n < 100 && rv[1] !== 1'b1; n++)
      rd(5'h06);
    check("expansion flags", 16'h000F, rv & 16'h000F);
  endtask : poll_page

  task automatic wait_link;
    for (int n = 0; n < 400 && MODE.link_up !== 1'b1; n++)
      @(posedge CLOCK);
  endtask : wait_link

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  // main sequence
  initial
  begin
    {RSTN, FORCED_AT_RESET, REG_WRITE, REG_READ} = '0;
    do_reset(1'b0);
    for (k = 0; k < 7; k++)
      rdc(rs_idx[k], rs_msk[k], rs_exp[k], "reset value");
    $display("reset values done");
    for (k = 0; k < 4; k++)
    begin
      partner_u.set_line(1'b0, 1'b0, 1'b0);
      wr(5'h04, pd_adv[k]);
      partner_u.set_line(pd_lnk[k][1], pd_lnk[k][0], 1'b0);
      wr(5'h00, 16'h1200);
      wait_link;
      rdc(5'h01, 16'h0024, (k < 2) ? 16'h0024 : 16'h0000, "pd status");
      rdc(5'h06, 16'h0011, (k < 2) ? 16'h0000 : 16'h0010, "pd expansion");
      check("pd link", 16'(k < 2), 16'(MODE.link_up));
      if (k < 2)
      begin
        rdc(5'h05, 16'hFFFF, pd_lp[k], "pd partner word");
        check("pd speed", 16'(k == 0), 16'(MODE.speed_100));
      end
      if (k == 0)
      begin
        partner_u.set_line(1'b0, 1'b0, 1'b0);
        for (i = 0; i < 400 && MODE.link_up !== 1'b0; i++)
          @(posedge CLOCK);
        rdc(5'h01, 16'h0024, 16'h0000, "link loss status");
        check("resumed", 16'h1, 16'(MODE.flp_enable | MODE.tx_quiet));
      end
    end
    $display("parallel detect done");
    wr(5'h04, 16'h01E1);
    partner_u.set_line(1'b0, 1'b0, 1'b1);
    wr(5'h00, 16'h1200);
    repeat (3) @(posedge CLOCK);
    check("break silence", 16'h1, 16'(MODE.tx_quiet & ~TX_PAGE.valid));
    for (i = 0; i < 300 && TX_PAGE.valid !== 1'b1; i++)
      @(posedge CLOCK);
    check("base page sent", 16'h01E1, TX_PAGE.word);
    partner_u.send_page(16'hE1E1);
    poll_page;
    rdc(5'h05, 16'hFFFF, 16'hE1E1, "base page");
    wr(5'h07, 16'h0123);
    for (i = 0; i < 300 && TX_PAGE.word !== 16'h0123; i++)
      @(posedge CLOCK);
    check("next page sent", 16'h0123, TX_PAGE.word);
    partner_u.send_page(16'h4456);
    poll_page;
    rdc(5'h05, 16'hFFFF, 16'h4456, "next page");
    partner_u.set_line(1'b0, 1'b1, 1'b0);
    wait_link;
    check("negotiated mode", 16'h3, 16'({MODE.speed_100, MODE.full_duplex}));
    rdc(5'h01, 16'h0034, 16'h0034, "negotiated status");
    $display("page exchange done");
    do_reset(1'b1);
    rdc(5'h00, 16'h1000, 16'h0000, "forced enable");
    wr(5'h00, 16'h1000);
    repeat (100) @(posedge CLOCK);
    check("not armed", 16'h0, 16'({MODE.tx_quiet, MODE.flp_enable, TX_PAGE.valid}));
    wr(5'h00, 16'h2100);
    repeat (3) @(posedge CLOCK);
    check("forced 100 full", 16'h3, 16'({MODE.speed_100, MODE.full_duplex}));
    wr(5'h00, 16'h0000);
    repeat (3) @(posedge CLOCK);
    check("forced 10 half", 16'h0, 16'({MODE.speed_100, MODE.full_duplex}));
    wr(5'h00, 16'h1000);
    for (i = 0; i < 100 && (MODE.tx_quiet | MODE.flp_enable) !== 1'b1; i++)
      @(posedge CLOCK);
    check("armed", 16'h1, 16'(MODE.tx_quiet | MODE.flp_enable));
    $display("forced mode done");
    finish_test;
  end

  // cuts a hung run short
  initial
  begin
    repeat (30000) @(posedge CLOCK);
    miscompares++;
    finish_test;
  end
endmodule : ancs_top_test

bind ancs_top ancs_top_assertions #(.PRESCALE(PRESCALE), .BREAK_LINK_MS(BREAK_LINK_MS)) chk_u (
  .CLOCK(CLOCK), .RSTN(RSTN), .REG_READ(REG_READ), .REG_INDEX(REG_INDEX),
  .REG_RDATA(REG_RDATA), .LINK_10_OK(LINK_10_OK), .LINK_100_OK(LINK_100_OK),
  .TX_PAGE(TX_PAGE), .MODE(MODE));
